/* common/slsr_pkg.sv */
// Purpose: Constants for the synthesizer readback status register block
// Assumes: AXI4-Lite, 32-bit data, register index times four is the byte address
// Notes: Registers are 16 bits wide, upper half of each word reads zero
//
// Summary of operation
// - Lock state readback at bits 10:9: low, invalid, locked, high.
// - Selected oscillator core number, codes 1 to 7, at bits 7:5.
// - Calibrated capacitor bank code at bits 7:0, upper byte zero.
// - Calibrated amplitude DAC setting at bits 8:0, bits 15:9 zero.
// - Reserved read-only bits and words read zero; writes do nothing.
package slsr_pkg;

	// ****************************************
	// Register indices
	// ****************************************
	localparam logic [9:0] IDX_RSVD_A = 10'h06d;
	localparam logic [9:0] IDX_LOCK_CORE = 10'h06e;
	localparam logic [9:0] IDX_CAP = 10'h06f;
	localparam logic [9:0] IDX_DAC = 10'h070;
	localparam logic [9:0] IDX_RSVD_B = 10'h071;
	localparam logic [9:0] IDX_RSVD_WZ = 10'h072;
	localparam logic [9:0] IDX_IRQ_STAT = 10'h073;
	localparam logic [9:0] IDX_IRQ_MASK = 10'h074;

	// ****************************************
	// Field layout
	// ****************************************
	localparam int LOCK_LSB = 9;
	localparam int LOCK_W = 2;
	localparam int CORE_LSB = 5;
	localparam int CORE_W = 3;
	localparam int CAP_LSB = 0;
	localparam int CAP_W = 8;
	localparam int DAC_LSB = 0;
	localparam int DAC_W = 9;
	localparam int REG_W = 16;

	// Lock state codes
	localparam logic [1:0] LOCK_LOW = 2'h0;
	localparam logic [1:0] LOCK_INVALID = 2'h1;
	localparam logic [1:0] LOCK_LOCKED = 2'h2;
	localparam logic [1:0] LOCK_HIGH = 2'h3;

	// ****************************************
	// Interrupt bits
	// ****************************************
	localparam int EV_W = 3;
	localparam int EV_CAL_DONE = 0;
	localparam int EV_LOCK_CHG = 1;
	localparam int EV_WZ_NONZERO = 2;

	// ****************************************
	// Reset values and responses
	// ****************************************
	localparam logic [15:0] RST_REG = 16'h0000;
	localparam logic [1:0] RST_LOCK = 2'h0;
	localparam logic [2:0] RST_CORE = 3'h0;
	localparam logic [7:0] RST_CAP = 8'h00;
	localparam logic [8:0] RST_DAC = 9'h000;
	localparam logic [2:0] RST_EV = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int SYNC_STAGES = 2;

endpackage

/* design/slsr_sync.sv */
// Purpose: Two-flop synchroniser for a bundle of pin inputs
// Assumes: Multi-bit inputs are quasi-static around their qualifying strobe
// Notes: First stage is read only by the second stage
`timescale 1ns/100ps
module slsr_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	// ****************************************
	// Synchroniser stages
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= d_i;
			sync_ff <= meta_ff;
		end
	end

	assign q_o = sync_ff;

endmodule

/* design/slsr_irq.sv */
// Purpose: Sticky event flags, mask and level interrupt
// Assumes: Clear vector is a one-cycle write-one-to-clear
// Notes: A set in the clearing cycle wins, so no event is lost
`timescale 1ns/100ps
module slsr_irq #(
	parameter int N = 3
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [N-1:0] ev_i,
	input wire logic [N-1:0] clr_i,
	input wire logic mask_we_i,
	input wire logic [N-1:0] mask_d_i,
	output logic [N-1:0] status_o,
	output logic [N-1:0] mask_o,
	output logic irq_o
);

	logic [N-1:0] status_ff;
	logic [N-1:0] mask_ff;
	logic irq_ff;

	// ****************************************
	// Status, mask, interrupt
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			status_ff <= '0;
		end else begin
			status_ff <= (status_ff & ~clr_i) | ev_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			mask_ff <= '0;
		end else if (mask_we_i) begin
			mask_ff <= mask_d_i;
		end
	end

	// One cycle behind status, keeps the output a plain flop
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(status_ff & mask_ff);
		end
	end

	assign status_o = status_ff;
	assign mask_o = mask_ff;
	assign irq_o = irq_ff;

	AST_SET_WINS: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(ev_i != '0) |=> ((status_ff & $past(ev_i)) == $past(ev_i)))
		else $error("Event lost against clear");

	AST_IRQ_LEVEL: assert property (@(posedge clk_i) disable iff (!resetn_i)
		|(status_ff & mask_ff) |=> irq_ff)
		else $error("Interrupt not raised for unmasked flag");

endmodule

/* design/slsr_top.sv */
// Purpose: Readback status registers of the synthesizer over AXI4-Lite
// Assumes: Calibration results are stable when the done strobe rises
// Notes: All inputs from the analog side pass two flops first
`timescale 1ns/100ps
module slsr_top #(
	parameter int AW = 12
) (
	input wire logic CLK_I,
	input wire logic RESETN_I,
	input wire logic [AW-1:0] AWADDR_I,
	input wire logic AWVALID_I,
	output logic AWREADY_O,
	input wire logic [31:0] WDATA_I,
	input wire logic [3:0] WSTRB_I,
	input wire logic WVALID_I,
	output logic WREADY_O,
	output logic [1:0] BRESP_O,
	output logic BVALID_O,
	input wire logic BREADY_I,
	input wire logic [AW-1:0] ARADDR_I,
	input wire logic ARVALID_I,
	output logic ARREADY_O,
	output logic [31:0] RDATA_O,
	output logic [1:0] RRESP_O,
	output logic RVALID_O,
	input wire logic RREADY_I,
	input wire logic [1:0] LOCK_STATE_I,
	input wire logic CAL_DONE_I,
	input wire logic [2:0] CORE_SEL_I,
	input wire logic [7:0] CAP_CODE_I,
	input wire logic [8:0] DAC_SET_I,
	output logic IRQ_O
);

	// ****************************************
	// Functions
	// ****************************************
	function automatic logic [9:0] idx_of(input logic [AW-1:0] a);
		idx_of = 10'(a >> 2);
	endfunction

	function automatic logic is_mapped(input logic [9:0] idx);
		is_mapped = (idx >= slsr_pkg::IDX_RSVD_A) && (idx <= slsr_pkg::IDX_IRQ_MASK);
	endfunction

	function automatic logic [31:0] rd_word(
		input logic [9:0] idx,
		input logic [1:0] lock,
		input logic [2:0] core,
		input logic [7:0] cap,
		input logic [8:0] dac,
		input logic [15:0] wz,
		input logic [2:0] stat,
		input logic [2:0] mask
	);
		rd_word = 32'h0;
		case (idx)
			slsr_pkg::IDX_LOCK_CORE: begin
				rd_word[slsr_pkg::LOCK_LSB +: slsr_pkg::LOCK_W] = lock;
				rd_word[slsr_pkg::CORE_LSB +: slsr_pkg::CORE_W] = core;
			end
			slsr_pkg::IDX_CAP: begin
				rd_word[slsr_pkg::CAP_LSB +: slsr_pkg::CAP_W] = cap;
			end
			slsr_pkg::IDX_DAC: begin
				rd_word[slsr_pkg::DAC_LSB +: slsr_pkg::DAC_W] = dac;
			end
			slsr_pkg::IDX_RSVD_WZ: begin
				rd_word[slsr_pkg::REG_W-1:0] = wz;
			end
			slsr_pkg::IDX_IRQ_STAT: begin
				rd_word[slsr_pkg::EV_W-1:0] = stat;
			end
			slsr_pkg::IDX_IRQ_MASK: begin
				rd_word[slsr_pkg::EV_W-1:0] = mask;
			end
			default: begin
				rd_word = 32'h0;
			end
		endcase
	endfunction

	// ****************************************
	// Input synchronisation
	// ****************************************
	logic [22:0] sync_q;
	logic [1:0] lock_s;
	logic done_s;
	logic [2:0] core_s;
	logic [7:0] cap_s;
	logic [8:0] dac_s;

	slsr_sync #(
		.W(23)
	) u_sync (
		.clk_i(CLK_I),
		.resetn_i(RESETN_I),
		.d_i({LOCK_STATE_I, CAL_DONE_I, CORE_SEL_I, CAP_CODE_I, DAC_SET_I}),
		.q_o(sync_q)
	);

	assign {lock_s, done_s, core_s, cap_s, dac_s} = sync_q;

	// ****************************************
	// Status capture
	// ****************************************
	logic done_d_ff;
	logic done_rise;
	logic [1:0] lock_ff;
	logic [2:0] core_ff;
	logic [7:0] cap_ff;
	logic [8:0] dac_ff;

	assign done_rise = done_s & ~done_d_ff;

	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			done_d_ff <= 1'b0;
		end else begin
			done_d_ff <= done_s;
		end
	end

	// Lock follows the comparator every cycle
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			lock_ff <= slsr_pkg::RST_LOCK;
		end else begin
			lock_ff <= lock_s;
		end
	end

	// Calibration results only move on a new calibration
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			core_ff <= slsr_pkg::RST_CORE;
			cap_ff <= slsr_pkg::RST_CAP;
			dac_ff <= slsr_pkg::RST_DAC;
		end else if (done_rise) begin
			core_ff <= core_s;
			cap_ff <= cap_s;
			dac_ff <= dac_s;
		end
	end

	// ****************************************
	// Write channel
	// ****************************************
	logic awready_ff;
	logic wready_ff;
	logic aw_held_ff;
	logic w_held_ff;
	logic [9:0] aw_idx_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic wr_go;
	logic [15:0] wr_val;

	assign wr_go = aw_held_ff & w_held_ff & ~bvalid_ff;
	assign wr_val = wdata_ff[15:0];

	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			awready_ff <= 1'b1;
			aw_held_ff <= 1'b0;
			aw_idx_ff <= 10'h000;
		end else if (AWVALID_I && awready_ff) begin
			awready_ff <= 1'b0;
			aw_held_ff <= 1'b1;
			aw_idx_ff <= idx_of(AWADDR_I);
		end else if (wr_go) begin
			aw_held_ff <= 1'b0;
		end else if (bvalid_ff && BREADY_I) begin
			awready_ff <= 1'b1;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			wready_ff <= 1'b1;
			w_held_ff <= 1'b0;
			wdata_ff <= 32'h0;
			wstrb_ff <= 4'h0;
		end else if (WVALID_I && wready_ff) begin
			wready_ff <= 1'b0;
			w_held_ff <= 1'b1;
			wdata_ff <= WDATA_I;
			wstrb_ff <= WSTRB_I;
		end else if (wr_go) begin
			w_held_ff <= 1'b0;
		end else if (bvalid_ff && BREADY_I) begin
			wready_ff <= 1'b1;
		end
	end

	// Read-only words accept the write and answer OKAY without change
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= slsr_pkg::RESP_OKAY;
		end else if (wr_go) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= is_mapped(aw_idx_ff) ? slsr_pkg::RESP_OKAY : slsr_pkg::RESP_SLVERR;
		end else if (bvalid_ff && BREADY_I) begin
			bvalid_ff <= 1'b0;
		end
	end

	// ****************************************
	// Writable words
	// ****************************************
	logic [15:0] wz_ff;
	logic wz_we;
	logic [15:0] nxt_wz;

	assign wz_we = wr_go && (aw_idx_ff == slsr_pkg::IDX_RSVD_WZ);

	always_comb begin
		nxt_wz = wz_ff;
		if (wstrb_ff[0]) begin
			nxt_wz[7:0] = wr_val[7:0];
		end
		if (wstrb_ff[1]) begin
			nxt_wz[15:8] = wr_val[15:8];
		end
	end

	// Stored as written; a nonzero value is flagged for software
	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			wz_ff <= slsr_pkg::RST_REG;
		end else if (wz_we) begin
			wz_ff <= nxt_wz;
		end
	end

	// ****************************************
	// Events and interrupt
	// ****************************************
	logic [2:0] ev;
	logic [2:0] clr;
	logic [2:0] irq_stat;
	logic [2:0] irq_mask;
	logic stat_we;
	logic mask_we;

	assign stat_we = wr_go && (aw_idx_ff == slsr_pkg::IDX_IRQ_STAT) && wstrb_ff[0];
	assign mask_we = wr_go && (aw_idx_ff == slsr_pkg::IDX_IRQ_MASK) && wstrb_ff[0];
	assign clr = stat_we ? wdata_ff[2:0] : slsr_pkg::RST_EV;

	always_comb begin
		ev = slsr_pkg::RST_EV;
		ev[slsr_pkg::EV_CAL_DONE] = done_rise;
		ev[slsr_pkg::EV_LOCK_CHG] = (lock_s != lock_ff);
		ev[slsr_pkg::EV_WZ_NONZERO] = wz_we && (nxt_wz != slsr_pkg::RST_REG);
	end

	slsr_irq #(
		.N(slsr_pkg::EV_W)
	) u_irq (
		.clk_i(CLK_I),
		.resetn_i(RESETN_I),
		.ev_i(ev),
		.clr_i(clr),
		.mask_we_i(mask_we),
		.mask_d_i(wdata_ff[2:0]),
		.status_o(irq_stat),
		.mask_o(irq_mask),
		.irq_o(IRQ_O)
	);

	// ****************************************
	// Read channel
	// ****************************************
	logic arready_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic [9:0] rd_idx_ff;
	logic ar_hs;
	logic [9:0] ar_idx;

	assign ar_hs = ARVALID_I & arready_ff;
	assign ar_idx = idx_of(ARADDR_I);

	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0;
			rresp_ff <= slsr_pkg::RESP_OKAY;
			rd_idx_ff <= 10'h000;
		end else if (ar_hs) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rd_idx_ff <= ar_idx;
			rdata_ff <= rd_word(ar_idx, lock_ff, core_ff, cap_ff, dac_ff, wz_ff,
				irq_stat, irq_mask);
			rresp_ff <= is_mapped(ar_idx) ? slsr_pkg::RESP_OKAY : slsr_pkg::RESP_SLVERR;
		end else if (rvalid_ff && RREADY_I) begin
			rvalid_ff <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	assign AWREADY_O = awready_ff;
	assign WREADY_O = wready_ff;
	assign BVALID_O = bvalid_ff;
	assign BRESP_O = bresp_ff;
	assign ARREADY_O = arready_ff;
	assign RVALID_O = rvalid_ff;
	assign RDATA_O = rdata_ff;
	assign RRESP_O = rresp_ff;

	// ****************************************
	// Checks
	// ****************************************
	AST_LOCK_FIELD: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		(ar_hs && ar_idx == slsr_pkg::IDX_LOCK_CORE) |=> (rdata_ff[10:9] == $past(lock_ff)))
		else $error("Lock field wrong on readback");

	AST_CORE_FIELD: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		(ar_hs && ar_idx == slsr_pkg::IDX_LOCK_CORE) |=>
		(rdata_ff[7:5] == $past(core_ff) && rdata_ff[4:0] == 5'h00 && rdata_ff[8] == 1'b0))
		else $error("Core field or neighbours wrong");

	AST_CAP_FIELD: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		(ar_hs && ar_idx == slsr_pkg::IDX_CAP) |=>
		(rdata_ff[7:0] == $past(cap_ff) && rdata_ff[31:8] == 24'h0))
		else $error("Capacitor code readback wrong");

	AST_DAC_FIELD: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		(ar_hs && ar_idx == slsr_pkg::IDX_DAC) |=>
		(rdata_ff[8:0] == $past(dac_ff) && rdata_ff[31:9] == 23'h0))
		else $error("Amplitude setting readback wrong");

	AST_RSVD_ZERO: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		(ar_hs && (ar_idx == slsr_pkg::IDX_RSVD_A || ar_idx == slsr_pkg::IDX_RSVD_B))
		|=> (rdata_ff == 32'h0 && rresp_ff == slsr_pkg::RESP_OKAY))
		else $error("Reserved word not zero");

	AST_CAL_HOLD: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		!done_rise |=> ($stable(cap_ff) && $stable(dac_ff) && $stable(core_ff)))
		else $error("Calibration result moved without calibration");

	AST_CAL_LOAD: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		done_rise |=> (cap_ff == $past(cap_s) && dac_ff == $past(dac_s) &&
		core_ff == $past(core_s)))
		else $error("Calibration result not captured");

	AST_WRITE_RESP: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
		wr_go |=> (bvalid_ff && (bresp_ff == slsr_pkg::RESP_OKAY) == is_mapped($past(aw_idx_ff))))
		else $error("Write response missing or wrong");

endmodule

/* bench/slsr_top_bench.sv */
// Purpose: Self-checking bench for the readback status registers
// Assumes: Byte address is register index times four, one read and one write at a time
// Notes: Integer model of every register is compared at each read and at the interrupt pin
`timescale 1ns/100ps
module slsr_top_bench;
	logic clk, resetn, awvalid, wvalid, bready, arvalid, rready, cal_done;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, lock_in;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [2:0] core_in;
	logic [7:0] cap_in;
	logic [8:0] dac_in;
	logic [31:0] d;
	logic [1:0] r;
	int fail_count, checked, seed, m_lock, m_core, m_cap, m_dac, m_wz, m_stat, m_mask, i;

	slsr_top dut_u (.CLK_I(clk), .RESETN_I(resetn), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
		.AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid),
		.WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
		.ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
		.RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .LOCK_STATE_I(lock_in),
		.CAL_DONE_I(cal_done), .CORE_SEL_I(core_in), .CAP_CODE_I(cap_in), .DAC_SET_I(dac_in),
		.IRQ_O(irq));

	// ****************************************
	// Clock and watchdog
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Whole run is about 300 cycles; generous margin
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		end_of_test();
	end

	// ****************************************
	// Helpers and model
	// ****************************************
	task automatic end_of_test();
		$display("checked=%0d fail_count=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	function automatic logic [31:0] m_data(input logic [9:0] idx);
		case (idx)
			slsr_pkg::IDX_LOCK_CORE: m_data = 32'((m_lock << 9) | (m_core << 5));
			slsr_pkg::IDX_CAP: m_data = 32'(m_cap);
			slsr_pkg::IDX_DAC: m_data = 32'(m_dac);
			slsr_pkg::IDX_RSVD_WZ: m_data = 32'(m_wz);
			slsr_pkg::IDX_IRQ_STAT: m_data = 32'(m_stat);
			slsr_pkg::IDX_IRQ_MASK: m_data = 32'(m_mask);
			default: m_data = 32'h0000_0000;
		endcase
	endfunction

	function automatic logic [1:0] m_resp(input logic [9:0] idx);
		if (idx < slsr_pkg::IDX_RSVD_A || idx > slsr_pkg::IDX_IRQ_MASK) begin
			m_resp = slsr_pkg::RESP_SLVERR;
		end else begin
			m_resp = slsr_pkg::RESP_OKAY;
		end
	endfunction

	// ****************************************
	// AXI4-Lite master
	// ****************************************
	// Entered just after a rising edge; ready held high so no reassignment in one step
	task automatic axi_wr(input logic [9:0] idx, input logic [31:0] dw, output logic [1:0] rs);
		logic done;
		done = 1'b0;
		rs = 2'h1;
		awaddr <= {idx, 2'h0};
		wdata <= dw;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		// No local limit: only the watchdog ends a wait
		while (!done) begin
			@(posedge clk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1 && bready) begin
				rs = bresp;
				done = 1'b1;
			end
		end
	endtask

	task automatic axi_rd(input logic [9:0] idx, output logic [31:0] dr, output logic [1:0] rs);
		logic done;
		done = 1'b0;
		dr = 32'h0000_0000;
		rs = 2'h1;
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		while (!done) begin
			@(posedge clk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1 && rready) begin
				dr = rdata;
				rs = rresp;
				done = 1'b1;
			end
		end
	endtask

	task automatic rd_chk(input logic [9:0] idx);
		logic [31:0] dr;
		logic [1:0] rs;
		axi_rd(idx, dr, rs);
		chk(dr, m_data(idx));
		chk({30'h0, rs}, {30'h0, m_resp(idx)});
	endtask

	// Results held 4 cycles either side of the strobe, past the 3 the pins need
	task automatic calibrate();
		core_in <= 3'(($unsigned($random(seed)) % 7) + 1);
		cap_in <= 8'($random(seed));
		dac_in <= 9'($random(seed));
		cyc(4);
		cal_done <= 1'b1;
		cyc(4);
		cal_done <= 1'b0;
		cyc(4);
		m_core = core_in;
		m_cap = cap_in;
		m_dac = dac_in;
		m_stat = m_stat | 1;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		{awvalid, wvalid, arvalid, cal_done} = 4'h0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{bready, rready} = 2'h3;
		{lock_in, core_in, cap_in, dac_in} = '0;
		{fail_count, checked, m_lock, m_core, m_cap, m_dac, m_wz, m_stat, m_mask} = '0;
		seed = 32;
		resetn = 1'b0;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		for (i = 'h6c; i <= 'h76; i++) rd_chk(10'(i));
		for (i = 0; i < 4; i++) begin
			calibrate();
			rd_chk(slsr_pkg::IDX_LOCK_CORE);
			rd_chk(slsr_pkg::IDX_CAP);
			rd_chk(slsr_pkg::IDX_DAC);
			// Results move without a strobe: readback must hold
			cap_in <= ~cap_in;
			dac_in <= ~dac_in;
			core_in <= ~core_in;
			cyc(6);
			rd_chk(slsr_pkg::IDX_CAP);
			rd_chk(slsr_pkg::IDX_DAC);
			rd_chk(slsr_pkg::IDX_LOCK_CORE);
		end
		for (i = 1; i <= 4; i++) begin
			lock_in <= 2'(i);
			m_lock = i % 4;
			m_stat = m_stat | 2;
			cyc(5);
			rd_chk(slsr_pkg::IDX_LOCK_CORE);
		end
		for (i = 'h6d; i <= 'h71; i++) begin
			axi_wr(10'(i), 32'hffff_ffff, r);
			chk({30'h0, r}, {30'h0, slsr_pkg::RESP_OKAY});
			rd_chk(10'(i));
		end
		axi_wr(10'h075, 32'h0000_ffff, r);
		chk({30'h0, r}, {30'h0, slsr_pkg::RESP_SLVERR});
		axi_wr(slsr_pkg::IDX_RSVD_WZ, 32'h0000_0000, r);
		chk({30'h0, r}, {30'h0, slsr_pkg::RESP_OKAY});
		rd_chk(slsr_pkg::IDX_RSVD_WZ);
		// Interrupt: masked, unmasked, cleared bit by bit, then raised again
		cyc(3);
		chk({31'h0, irq}, 32'h0000_0000);
		axi_wr(slsr_pkg::IDX_IRQ_MASK, 32'h0000_0001, r);
		m_mask = 1;
		cyc(3);
		chk({31'h0, irq}, 32'h0000_0001);
		rd_chk(slsr_pkg::IDX_IRQ_MASK);
		rd_chk(slsr_pkg::IDX_IRQ_STAT);
		axi_wr(slsr_pkg::IDX_IRQ_STAT, 32'h0000_0002, r);
		m_stat = m_stat & 5;
		rd_chk(slsr_pkg::IDX_IRQ_STAT);
		cyc(3);
		chk({31'h0, irq}, 32'h0000_0001);
		axi_wr(slsr_pkg::IDX_IRQ_STAT, 32'h0000_0007, r);
		m_stat = 0;
		cyc(3);
		chk({31'h0, irq}, 32'h0000_0000);
		rd_chk(slsr_pkg::IDX_IRQ_STAT);
		calibrate();
		cyc(3);
		chk({31'h0, irq}, 32'h0000_0001);
		rd_chk(slsr_pkg::IDX_IRQ_STAT);
		rd_chk(slsr_pkg::IDX_CAP);
		// Mid-run reset: every word back to zero, interrupt low
		resetn <= 1'b0;
		cyc(3);
		resetn <= 1'b1;
		{m_lock, m_core, m_cap, m_dac, m_wz, m_stat, m_mask} = '0;
		@(posedge clk);
		chk({31'h0, irq}, 32'h0000_0000);
		for (i = 'h6d; i <= 'h74; i++) rd_chk(10'(i));
		end_of_test();
	end
endmodule
